// ==== hw/grs_gpio.sv ====
`timescale 1ns/1ns
module grs_gpio
  import grs_pkg::*;
#(
  parameter int WIDTH1 = 32,
  parameter int WIDTH2 = 32,
  parameter bit DUAL = 1'b0,
  parameter bit IRQ_EN = 1'b0,
  parameter logic [31:0] BASE_ADDR = 32'h00000000,
  parameter logic [31:0] DFLT_VALUE1 = RST_ZERO,
  parameter logic [31:0] DFLT_DIR1 = 32'hFFFFFFFF,
  parameter logic [31:0] DFLT_VALUE2 = RST_ZERO,
  parameter logic [31:0] DFLT_DIR2 = 32'hFFFFFFFF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // channel pins
  input wire logic [WIDTH1-1:0] chan1In,
  output logic [WIDTH1-1:0] chan1Out,
  output logic [WIDTH1-1:0] chan1Tri,
  input wire logic [WIDTH2-1:0] chan2In,
  output logic [WIDTH2-1:0] chan2Out,
  output logic [WIDTH2-1:0] chan2Tri,
  // interrupt
  output logic irq_out
);

  // width masks for each channel
  localparam logic [31:0] MASK1 = 32'hFFFFFFFF >> (32 - WIDTH1);
  localparam logic [31:0] MASK2 = 32'hFFFFFFFF >> (32 - WIDTH2);

  logic [31:0] value1_r, dir1_r, value2_r, dir2_r;
  logic masterEn_r;
  logic [1:0] flags_r, chanMask_r;
  logic [31:0] in1_r, in2_r;
  logic bValid_r, rValid_r;
  logic [31:0] rData_r;
  logic [31:0] rData_nxt;
  logic wrFire, rdFire;
  logic [8:0] wOfs, rOfs;
  logic [1:0] event_nxt;
  logic [31:0] pin1, pin2;

  // block-relative offset of a bus address, or an out-of-range marker
  function automatic logic [9:0] relOfs(input logic [31:0] addr);
    logic [31:0] d;
    d = addr - BASE_ADDR;
    relOfs = (d[31:9] == 23'h0) ? {1'b1, d[8:0]} : 10'h0;
  endfunction : relOfs

  // take a write only when address and data arrive together
  assign wrFire = s_axi_awvalid & s_axi_wvalid & ~bValid_r;
  assign rdFire = s_axi_arvalid & ~rValid_r;
  assign s_axi_awready = wrFire;
  assign s_axi_wready = wrFire;
  assign s_axi_arready = rdFire;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = RESP_OKAY;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rresp = RESP_OKAY;
  assign s_axi_rdata = rData_r;

  // offsets are decoded relative to the base
  always_comb begin
    logic [9:0] w;
    logic [9:0] r;
    w = relOfs(s_axi_awaddr);
    r = relOfs(s_axi_araddr);
    wOfs = w[9] ? w[8:0] : 9'h1FC;
    rOfs = r[9] ? r[8:0] : 9'h1FC;
  end

  // pins zero-extended to the word
  assign pin1 = 32'(chan1In);
  assign pin2 = 32'(chan2In);

  // write response channel
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bValid_r <= 1'b0;
    end else if (wrFire) begin
      bValid_r <= 1'b1;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  // channel one registers, full word written, strobes ignored
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      value1_r <= DFLT_VALUE1 & MASK1;
      dir1_r <= DFLT_DIR1 & MASK1;
    end else if (wrFire) begin
      if (wOfs == OFS_CH1_VALUE) begin
        // input bits keep their value
        value1_r <= ((s_axi_wdata & ~dir1_r) | (value1_r & dir1_r)) & MASK1;
      end
      if (wOfs == OFS_CH1_DIR) begin
        dir1_r <= s_axi_wdata & MASK1;
      end
    end
  end

  // channel two registers, only when dual
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      value2_r <= DUAL ? (DFLT_VALUE2 & MASK2) : RST_ZERO;
      dir2_r <= DUAL ? (DFLT_DIR2 & MASK2) : RST_ZERO;
    end else if (wrFire && DUAL) begin
      if (wOfs == OFS_CH2_VALUE) begin
        value2_r <= ((s_axi_wdata & ~dir2_r) | (value2_r & dir2_r)) & MASK2;
      end
      if (wOfs == OFS_CH2_DIR) begin
        dir2_r <= s_axi_wdata & MASK2;
      end
    end
  end

  // output and three-state pins straight from the registers
  assign chan1Out = value1_r[WIDTH1-1:0];
  assign chan1Tri = dir1_r[WIDTH1-1:0];
  assign chan2Out = value2_r[WIDTH2-1:0];
  assign chan2Tri = dir2_r[WIDTH2-1:0];

  // previous input samples for transition detection
  // reset takes the live pins so a pin idling high gives no false event
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in1_r <= pin1;
      in2_r <= pin2;
    end else begin
      in1_r <= pin1;
      in2_r <= pin2;
    end
  end

  // per-channel transition on an input bit
  assign event_nxt[0] = |((in1_r ^ pin1) & dir1_r);
  assign event_nxt[1] = DUAL & (|((in2_r ^ pin2) & dir2_r));

  // interrupt registers, present only with interrupts configured
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !IRQ_EN) begin
      masterEn_r <= 1'b0;
      chanMask_r <= 2'h0;
      flags_r <= 2'h0;
    end else begin
      if (wrFire && wOfs == OFS_MASTER_IRQ) begin
        masterEn_r <= s_axi_wdata[MASTER_EN_BIT];
      end
      if (wrFire && wOfs == OFS_IRQ_MASK) begin
        chanMask_r <= s_axi_wdata[1:0];
      end
      // toggle on write, a new event sets and wins
      if (wrFire && wOfs == OFS_IRQ_FLAGS) begin
        flags_r <= (flags_r ^ s_axi_wdata[1:0]) | event_nxt;
      end else begin
        flags_r <= flags_r | event_nxt;
      end
    end
  end

  // level interrupt gated by both enables
  assign irq_out = masterEn_r & |(flags_r & chanMask_r);

  // read mux, absent registers return zero
  always_comb begin
    rData_nxt = RST_ZERO;
    case (rOfs)
      OFS_CH1_VALUE: rData_nxt = pin1 & dir1_r & MASK1;
      OFS_CH1_DIR: rData_nxt = dir1_r;
      OFS_CH2_VALUE: rData_nxt = DUAL ? (pin2 & dir2_r & MASK2) : RST_ZERO;
      OFS_CH2_DIR: rData_nxt = DUAL ? dir2_r : RST_ZERO;
      OFS_MASTER_IRQ: rData_nxt = {masterEn_r, 31'h0};
      OFS_IRQ_FLAGS: rData_nxt = {30'h0, flags_r};
      OFS_IRQ_MASK: rData_nxt = {30'h0, chanMask_r};
      default: rData_nxt = RST_ZERO;
    endcase
  end

  // read data channel
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rValid_r <= 1'b0;
      rData_r <= RST_ZERO;
    end else if (rdFire) begin
      rValid_r <= 1'b1;
      rData_r <= rData_nxt;
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // direction write steers the three-state pin next cycle
  a_dir_drives_tri: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wrFire && wOfs == OFS_CH1_DIR) |=> (chan1Tri == $past(s_axi_wdata[WIDTH1-1:0])))
    else $error("direction write not on tri pins");

  // ignored strobes: full word lands in direction
  a_full_word_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wrFire && wOfs == OFS_CH1_DIR && s_axi_wstrb == 4'h0)
      |=> (dir1_r == ($past(s_axi_wdata) & MASK1)))
    else $error("strobes affected write");

  // input bits keep value across a data write
  a_input_bits_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wrFire && wOfs == OFS_CH1_VALUE) |=> ((value1_r & $past(dir1_r)) == ($past(value1_r) & $past(dir1_r))))
    else $error("write altered input bit");

  // output bits read as zero
  a_output_read_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rdFire && rOfs == OFS_CH1_VALUE) |=> ((s_axi_rdata & ~$past(dir1_r)) == 32'h0))
    else $error("output bit read nonzero");

  // absent channel two reads zero
  a_absent_read_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rdFire && !DUAL && rOfs == OFS_CH2_DIR) |=> (s_axi_rdata == 32'h0))
    else $error("absent register read nonzero");

  // toggle on write flips flags with no event
  a_flag_toggle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (IRQ_EN && wrFire && wOfs == OFS_IRQ_FLAGS && event_nxt == 2'h0)
      |=> (flags_r == ($past(flags_r) ^ $past(s_axi_wdata[1:0]))))
    else $error("status toggle wrong");

  // no interrupt without the master enable
  a_irq_master_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !masterEn_r |-> !irq_out)
    else $error("irq without master enable");

  // interrupt registers stay clear when not configured
  a_irq_absent: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !IRQ_EN |=> (flags_r == 2'h0 && !masterEn_r))
    else $error("interrupt state without option");

  // enabled input transition raises the interrupt
  a_event_raises_irq: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (IRQ_EN && event_nxt[0] && masterEn_r && chanMask_r[0]
      && !(wrFire && (wOfs == OFS_MASTER_IRQ || wOfs == OFS_IRQ_MASK))) |=> irq_out)
    else $error("transition missed");

  // channel one output bits take the written word
  a_ch1_value_ofs: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wrFire && wOfs == OFS_CH1_VALUE)
      |=> ((value1_r & ~$past(dir1_r)) == ($past(s_axi_wdata) & ~$past(dir1_r) & MASK1)))
    else $error("channel one data write lost");

  // channel two output bits take the written word
  a_ch2_value_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (DUAL && wrFire && wOfs == OFS_CH2_VALUE)
      |=> ((value2_r & ~$past(dir2_r)) == ($past(s_axi_wdata) & ~$past(dir2_r) & MASK2)))
    else $error("channel two data write lost");

  // channel two direction reaches its three-state pins
  a_tri2_follows: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (DUAL && wrFire && wOfs == OFS_CH2_DIR)
      |=> (chan2Tri == $past(s_axi_wdata[WIDTH2-1:0])))
    else $error("channel two direction not on tri pins");

  // single channel keeps the second pair cleared
  a_ch2_absent: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !DUAL |-> (value2_r == RST_ZERO && dir2_r == RST_ZERO))
    else $error("channel two state without option");

  // channel one input transition sets its flag
  a_flag_event_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (IRQ_EN && event_nxt[0]) |=> flags_r[0])
    else $error("channel one event not flagged");

  // channel two input transition sets its flag
  a_ch2_event_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (IRQ_EN && event_nxt[1]) |=> flags_r[1])
    else $error("channel two event not flagged");

  // channel mask write lands
  a_mask_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (IRQ_EN && wrFire && wOfs == OFS_IRQ_MASK) |=> (chanMask_r == $past(s_axi_wdata[1:0])))
    else $error("channel mask write lost");

  // master enable write lands
  a_gie_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (IRQ_EN && wrFire && wOfs == OFS_MASTER_IRQ)
      |=> (masterEn_r == $past(s_axi_wdata[MASTER_EN_BIT])))
    else $error("master enable write lost");

  // no state above the channel width
  a_width_masked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((value1_r & ~MASK1) == RST_ZERO && (dir1_r & ~MASK1) == RST_ZERO))
    else $error("bits above width set");

  // input bits read the pin
  a_input_read_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rdFire && rOfs == OFS_CH1_VALUE)
      |=> ((s_axi_rdata & $past(dir1_r)) == ($past(pin1) & $past(dir1_r) & MASK1)))
    else $error("input bit read wrong");

  // unmapped write leaves channel one alone
  a_unmapped_no_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wrFire && wOfs == 9'h1FC) |=> (value1_r == $past(value1_r) && dir1_r == $past(dir1_r)))
    else $error("unmapped write changed state");

  // direction reads back as written
  a_dir_read_back: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rdFire && rOfs == OFS_CH1_DIR) |=> (s_axi_rdata == $past(dir1_r)))
    else $error("direction read wrong");

  // defaults in force right after reset
  a_reset_defaults: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $past(sys_rst) |-> (value1_r == (DFLT_VALUE1 & MASK1) && dir1_r == (DFLT_DIR1 & MASK1)
      && flags_r == 2'h0 && !irq_out))
    else $error("reset defaults wrong");

  // a write is only taken with address and data together
  a_write_needs_both: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_axi_awready |-> (s_axi_awvalid && s_axi_wvalid))
    else $error("write taken without both valids");

  // fully masked channels never interrupt
  a_irq_mask_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (chanMask_r == 2'h0) |-> !irq_out)
    else $error("irq with all channels masked");

endmodule : grs_gpio

// ==== hw/grs_pkg.sv ====
package grs_pkg;
  localparam logic [8:0] OFS_CH1_VALUE = 9'h000;
  localparam logic [8:0] OFS_CH1_DIR = 9'h004;
  localparam logic [8:0] OFS_CH2_VALUE = 9'h008;
  localparam logic [8:0] OFS_CH2_DIR = 9'h00C;
  localparam logic [8:0] OFS_MASTER_IRQ = 9'h11C;
  localparam logic [8:0] OFS_IRQ_FLAGS = 9'h120;
  localparam logic [8:0] OFS_IRQ_MASK = 9'h128;
  localparam int MASTER_EN_BIT = 31;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage : grs_pkg

// ==== tb/gpio_register_space_tb_top.sv ====
`timescale 1ns/1ns
module gpio_register_space_tb_top;
  import grs_pkg::*;
  localparam logic [31:0] BASE = 32'h00001000;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] awaddr, wdata, araddr, rdata, rv;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, arvalid, arready;
  logic bvalid, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] chan1In = 8'h00;
  logic [7:0] chan1Out, chan1Tri;
  logic [3:0] chan2In = 4'h0;
  logic [3:0] chan2Out, chan2Tri;
  logic irqOut;
  int fails = 0;
  int comparisons = 0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  grs_gpio #(.WIDTH1(8), .WIDTH2(4), .DUAL(1'b1), .IRQ_EN(1'b1), .BASE_ADDR(BASE),
    .DFLT_VALUE1(32'h000000A5), .DFLT_DIR1(32'h0000000F)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .chan1In(chan1In), .chan1Out(chan1Out), .chan1Tri(chan1Tri),
    .chan2In(chan2In), .chan2Out(chan2Out), .chan2Tri(chan2Tri), .irq_out(irqOut));

  grs_axi_master i_master (
    .ref_clk(ref_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_wready(wready),
    .s_axi_bvalid(bvalid), .s_axi_bresp(bresp), .s_axi_rvalid(rvalid), .s_axi_rresp(rresp));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // read a bus address and compare
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    i_master.rd(a, rv);
    chk(nm, rv, exp);
    chk("rresp", {29'h0, i_master.lastR}, 32'h00000004);
  endtask : rchk

  task automatic end_of_test();
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // watchdog
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("out1_rst", {24'h0, chan1Out}, 32'h000000A5);
    chk("tri1_rst", {24'h0, chan1Tri}, 32'h0000000F);
    rchk("val1_rst", BASE + 32'(OFS_CH1_VALUE), 32'h00000000);
    i_master.wr(BASE + 32'(OFS_CH1_VALUE), 32'h12345678);
    chk("out1_wr", {24'h0, chan1Out}, 32'h00000075);
    chk("bresp", {29'h0, i_master.lastB}, 32'h00000004);
    i_master.wr(BASE + 32'(OFS_CH1_DIR), 32'hFFFFFFF0);
    rchk("dir1", BASE + 32'(OFS_CH1_DIR), 32'h000000F0);
    chk("tri1", {24'h0, chan1Tri}, 32'h000000F0);
    i_master.wr(BASE + 32'(OFS_CH2_DIR), 32'h00000000);
    chk("tri2", {28'h0, chan2Tri}, 32'h00000000);
    i_master.wr(BASE + 32'(OFS_CH2_VALUE), 32'hFFFFFFFF);
    chk("out2", {28'h0, chan2Out}, 32'h0000000F);
    rchk("val2", BASE + 32'(OFS_CH2_VALUE), 32'h00000000);
    rchk("dir2", BASE + 32'(OFS_CH2_DIR), 32'h00000000);
    rchk("hole", BASE + 32'h00000010, 32'h00000000);
    rchk("below_base", 32'h00000000 + 32'(OFS_CH1_DIR), 32'h00000000);
    i_master.wr(BASE + 32'(OFS_IRQ_MASK), 32'h00000003);
    i_master.wr(BASE + 32'(OFS_MASTER_IRQ), 32'h80000000);
    rchk("mask", BASE + 32'(OFS_IRQ_MASK), 32'h00000003);
    rchk("gie", BASE + 32'(OFS_MASTER_IRQ), 32'h80000000);
    chk("irq_idle", {31'h0, irqOut}, 32'h00000000);
    @(negedge ref_clk);
    chan1In = 8'h30;
    repeat (3) @(negedge ref_clk);
    chk("irq_set", {31'h0, irqOut}, 32'h00000001);
    rchk("flags", BASE + 32'(OFS_IRQ_FLAGS), 32'h00000001);
    rchk("pin1", BASE + 32'(OFS_CH1_VALUE), 32'h00000030);
    rchk("val1_ofs", BASE + 32'(OFS_CH1_VALUE), 32'h00000030);
    i_master.wr(BASE + 32'(OFS_IRQ_FLAGS), 32'h00000001);
    rchk("flags_clr", BASE + 32'(OFS_IRQ_FLAGS), 32'h00000000);
    chk("irq_clr", {31'h0, irqOut}, 32'h00000000);
    i_master.wr(BASE + 32'(OFS_IRQ_FLAGS), 32'h00000002);
    rchk("flags_set", BASE + 32'(OFS_IRQ_FLAGS), 32'h00000002);
    chk("irq_ch2", {31'h0, irqOut}, 32'h00000001);
    end_of_test();
  end
endmodule : gpio_register_space_tb_top

// ==== tb/grs_axi_master.sv ====
`timescale 1ns/1ns
module grs_axi_master (
  // clock
  input wire logic ref_clk,
  // write side
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  // read side
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  // handshake and response
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp
);
  // last response seen as {valid, resp}
  logic [2:0] lastB;
  logic [2:0] lastR;

  // idle values at time zero; response readies are held high elsewhere
  initial begin
    s_axi_awaddr = 32'h00000000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_araddr = 32'h00000000;
    s_axi_arvalid = 1'b0;
  end

  // single write; strobes left low to show they do not matter
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    s_axi_awaddr = a;
    s_axi_wdata = d;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    #1;
    while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1) && n < 50) begin
      @(negedge ref_clk);
      #1;
      n++;
    end
    // taken at the coming rising edge; response stands in the cycle after
    @(negedge ref_clk);
    lastB = {s_axi_bvalid, s_axi_bresp};
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    // released lines show the inverse so stale values never look valid
    s_axi_awaddr = ~a;
    s_axi_wdata = ~d;
  endtask : wr

  // single read; data taken at the edge where the answer stands
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    #1;
    while (s_axi_arready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      #1;
      n++;
    end
    // data stands in the cycle after the taking edge
    @(negedge ref_clk);
    d = s_axi_rdata;
    lastR = {s_axi_rvalid, s_axi_rresp};
    s_axi_arvalid = 1'b0;
    s_axi_araddr = ~a;
  endtask : rd
endmodule : grs_axi_master
